// >>> inc/cmd_decode_pkg.sv
package cmd_decode_pkg;
    // Address and bank widths of the command front end.
    localparam int ADDR_W = 13;
    localparam int BANK_W = 2;
    localparam int NUM_BANKS = 4;
    localparam int COL_W = 9;
    localparam int MODE_W = 13;
    // Bit position of the auto precharge / all-banks address input.
    localparam int AP_BIT = 10;
    // Reset values of stored state.
    localparam logic [ADDR_W-1:0] ROW_RESET = 13'h0000;
    localparam logic [MODE_W-1:0] MODE_RESET = 13'h0000;
    localparam logic [COL_W-1:0] COL_RESET = 9'h000;

    // Decoded command kinds.
    typedef enum logic [3:0] {
        CMD_NONE,
        CMD_OPEN_ROW,
        CMD_PRE_ONE,
        CMD_PRE_ALL,
        CMD_READ,
        CMD_WRITE,
        CMD_MODE_LOAD,
        CMD_REFRESH,
        CMD_BURST_STOP
    } cmd_e;
endpackage : cmd_decode_pkg

// >>> inc/cmd_if.sv
`timescale 1ns/1ps
// Carries one decoded command from the decoder to the bank tracker.
interface cmd_if;
    import cmd_decode_pkg::*;
    logic valid;
    cmd_e cmd;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;

    // The decoder drives the command.
    modport src (output valid, output cmd, output bank, output addr);
    // The bank tracker consumes it.
    modport dst (input valid, input cmd, input bank, input addr);
endinterface : cmd_if

// >>> rtl/cmd_decoder.sv
`timescale 1ns/1ps
// Turns the sampled strobes into one command per clock.
module cmd_decoder
    import cmd_decode_pkg::*;
(
    // Sampled pins.
    input wire logic sel_n,
    input wire logic row_n,
    input wire logic col_n,
    input wire logic wr_n,
    input wire logic [BANK_W-1:0] bank_in,
    input wire logic [ADDR_W-1:0] addr_in,
    // Decoded command.
    cmd_if.src cmd_o
);
    // The decode is pure logic; the top registers its effects.
    always_comb
    begin
        cmd_o.bank = bank_in;
        cmd_o.addr = addr_in;
        cmd_o.cmd = CMD_NONE;
        // R7 deselect masks all
        if (!sel_n)
        begin
            // R9 four line code
            case ({row_n, col_n, wr_n})
                // R10 open row code
                3'h3: cmd_o.cmd = CMD_OPEN_ROW;
                // R11 precharge code, R4 all banks
                3'h2: cmd_o.cmd = addr_in[AP_BIT] ? CMD_PRE_ALL
                                                  : CMD_PRE_ONE;
                // R13 column write
                3'h4: cmd_o.cmd = CMD_WRITE;
                // R13 column read
                3'h5: cmd_o.cmd = CMD_READ;
                // R6 mode load code
                3'h0: cmd_o.cmd = CMD_MODE_LOAD;
                3'h1: cmd_o.cmd = CMD_REFRESH;
                3'h6: cmd_o.cmd = CMD_BURST_STOP;
                default: cmd_o.cmd = CMD_NONE;
            endcase
        end
        cmd_o.valid = (cmd_o.cmd != CMD_NONE);
    end
endmodule : cmd_decoder

// >>> rtl/sdram_bank_row_command_decode.sv
`timescale 1ns/1ps
// How it works
// R1 - Two bank inputs pick bank A to D.
// R2 - Open row latches all thirteen address bits.
// R3 - Read/write takes column 0-8, bit 10 autoprecharge.
// R4 - Precharge with bit 10 high closes all.
// R5 - Precharge bit 10 low closes one bank.
// R6 - Mode load stores address as opcode.
// R7 - Select high masks every command.
// R8 - Controller steers ranks with select line.
// R9 - Strobes latched each rising edge form command.
// R10 - Code L L H H is open row.
// R11 - Code L L H L is precharge.
// R12 - Open row makes the bank active.
// R13 - Row high, column low: write or read.
module sdram_bank_row_command_decode
    import cmd_decode_pkg::*;
(
    // Clock and reset.
    input wire logic clock,
    input wire logic nrst,
    // Command pins from the memory controller.
    input wire logic dev_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bank_select_lo,
    input wire logic bank_select_hi,
    input wire logic [ADDR_W-1:0] addr_inputs,
    // Bank state.
    output logic [NUM_BANKS-1:0] bank_active,
    output logic [NUM_BANKS*ADDR_W-1:0] bank_rows,
    // Last column access.
    output logic access_pulse,
    output logic access_write,
    output logic access_auto_pre,
    output logic [BANK_W-1:0] access_bank,
    output logic [COL_W-1:0] access_col,
    // Mode configuration.
    output logic [MODE_W-1:0] mode_opcode,
    output logic mode_pulse,
    // Other decoded events, one-cycle pulses.
    output logic refresh_pulse,
    output logic burst_stop_pulse
);
    // All state of the block in one record.
    typedef struct packed {
        // Two-stage pin pipe; the decode reads only the second stage.
        logic [3:0] ctl_m;
        logic [3:0] ctl;
        logic [BANK_W-1:0] bank_m;
        logic [BANK_W-1:0] bank_s;
        logic [ADDR_W-1:0] addr_m;
        logic [ADDR_W-1:0] addr_s;
        // Open flag and open row of each bank.
        logic [NUM_BANKS-1:0] active;
        logic [NUM_BANKS-1:0][ADDR_W-1:0] rows;
        // Last column access; the fields other than the acc pulse hold until the next access.
        logic acc;
        logic acc_wr;
        logic acc_ap;
        logic [BANK_W-1:0] acc_bank;
        logic [COL_W-1:0] acc_col;
        // Mode opcode and the one-cycle event pulses.
        logic [MODE_W-1:0] mode;
        logic mode_p;
        logic ref_p;
        logic stop_p;
    } state_s;

    // Registered state and its next value.
    state_s st_r;
    state_s st_nxt;
    // Bank named by the decoded command.
    logic [BANK_W-1:0] bank_pick;

    // Decoded command, one per clock, from the decoder.
    cmd_if dec ();

    // The decode packs the bank into two select bits and reads the
    // auto precharge bit above the column field; other sizes would
    // silently alias banks or columns, so they are refused here.
    if (NUM_BANKS != (1 << BANK_W) || AP_BIT >= ADDR_W
        || COL_W > AP_BIT || MODE_W != ADDR_W)
    begin : g_bad_sizes
        $error("command decode sizes do not fit the address bus");
    end

    // Command decode of the second pin stage only; the first stage
    // only feeds the second, so a late pin cannot reach the decode.
    cmd_decoder u_dec (
        .sel_n(st_r.ctl[3]),
        .row_n(st_r.ctl[2]),
        .col_n(st_r.ctl[1]),
        .wr_n(st_r.ctl[0]),
        .bank_in(st_r.bank_s),
        .addr_in(st_r.addr_s),
        .cmd_o(dec.src)
    );

    assign bank_pick = dec.bank;

    // Next state from the decoded command. Commands act two edges after
    // the pins are sampled, so the effect shows after the third edge.
    always_comb
    begin
        st_nxt = st_r;
        // Two-stage pin pipe: a pin that moves near the edge can only
        // disturb the first stage, and the decode reads the second one.
        // R9 latch on edge
        st_nxt.ctl_m = {dev_select_n, row_strobe_n, col_strobe_n,
                        write_strobe_n};
        st_nxt.ctl = st_r.ctl_m;
        // R1 high input is msb
        st_nxt.bank_m = {bank_select_hi, bank_select_lo};
        st_nxt.bank_s = st_r.bank_m;
        st_nxt.addr_m = addr_inputs;
        st_nxt.addr_s = st_r.addr_m;
        // Pulses last one cycle only, so a command held on the pins for
        // several cycles gives one pulse for every cycle it is sampled.
        st_nxt.acc = 1'b0;
        st_nxt.mode_p = 1'b0;
        st_nxt.ref_p = 1'b0;
        st_nxt.stop_p = 1'b0;
        if (dec.valid)
        begin
            case (dec.cmd)
                CMD_OPEN_ROW:
                begin
                    // Reopening an open bank just reloads its row; the
                    // controller is trusted to precharge it first.
                    // R12 bank goes active, R2 full row latched
                    st_nxt.active[bank_pick] = 1'b1;
                    st_nxt.rows[bank_pick] = dec.addr;
                end
                CMD_PRE_ALL:
                    // The bank select lines play no part here.
                    // R4 all banks close
                    st_nxt.active = '0;
                CMD_PRE_ONE:
                    // Other banks keep their state and their rows.
                    // R5 one bank closes
                    st_nxt.active[bank_pick] = 1'b0;
                CMD_READ, CMD_WRITE:
                begin
                    // An access to an idle bank is not refused; it is
                    // still reported so that the data path can flag it.
                    // R3 column and autoprecharge
                    st_nxt.acc = 1'b1;
                    st_nxt.acc_wr = (dec.cmd == CMD_WRITE);
                    st_nxt.acc_ap = dec.addr[AP_BIT];
                    st_nxt.acc_bank = bank_pick;
                    st_nxt.acc_col = dec.addr[COL_W-1:0];
                    // No burst engine here, so auto precharge closes the
                    // bank at once rather than after the last beat.
                    if (dec.addr[AP_BIT])
                        st_nxt.active[bank_pick] = 1'b0;
                end
                CMD_MODE_LOAD:
                begin
                    // The opcode is kept whole; its fields are read
                    // by the blocks that use them.
                    // R6 opcode stored
                    st_nxt.mode = dec.addr;
                    st_nxt.mode_p = 1'b1;
                end
                CMD_REFRESH:
                    // Only reported; the refresh engine lives elsewhere.
                    st_nxt.ref_p = 1'b1;
                CMD_BURST_STOP:
                    // Only reported, for the burst engine to act on.
                    st_nxt.stop_p = 1'b1;
                default:
                    // No operation leaves the state alone.
                    st_nxt = st_nxt;
            endcase
        end
    end

    // State register. The outputs and the pin pipe all live here, so
    // every output comes from a flop and reset clears them together.
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            // Pins read as deselected so reset releases into a no-op.
            st_r.ctl_m <= 4'hf;
            st_r.ctl <= 4'hf;
            st_r.bank_m <= '0;
            st_r.bank_s <= '0;
            st_r.addr_m <= ROW_RESET;
            st_r.addr_s <= ROW_RESET;
            st_r.active <= 4'h0;
            st_r.rows <= '0;
            st_r.acc <= 1'b0;
            st_r.acc_wr <= 1'b0;
            st_r.acc_ap <= 1'b0;
            st_r.acc_bank <= 2'h0;
            st_r.acc_col <= COL_RESET;
            st_r.mode <= MODE_RESET;
            st_r.mode_p <= 1'b0;
            st_r.ref_p <= 1'b0;
            st_r.stop_p <= 1'b0;
        end
        else
            st_r <= st_nxt;
    end

    // Outputs straight from the state flops.
    // Nothing below adds logic, so no output can glitch.
    assign bank_active = st_r.active;
    assign bank_rows = st_r.rows;
    assign access_pulse = st_r.acc;
    assign access_write = st_r.acc_wr;
    assign access_auto_pre = st_r.acc_ap;
    assign access_bank = st_r.acc_bank;
    assign access_col = st_r.acc_col;
    assign mode_opcode = st_r.mode;
    assign mode_pulse = st_r.mode_p;
    assign refresh_pulse = st_r.ref_p;
    assign burst_stop_pulse = st_r.stop_p;
endmodule : sdram_bank_row_command_decode

// >>> tb/bank_cmd_chk.sv
`timescale 1ns/1ps
// Checks that each sampled command other than refresh and burst stop lands on the outputs three edges on.
module bank_cmd_chk
    import cmd_decode_pkg::*;
(
    // Clock, reset and pins.
    input wire logic clock,
    input wire logic nrst,
    input wire logic dev_select_n,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_strobe_n,
    input wire logic bank_select_lo,
    input wire logic bank_select_hi,
    input wire logic [ADDR_W-1:0] addr_inputs,
    // Decoded outputs.
    input wire logic [NUM_BANKS-1:0] bank_active,
    input wire logic [NUM_BANKS*ADDR_W-1:0] bank_rows,
    input wire logic access_pulse,
    input wire logic access_write,
    input wire logic access_auto_pre,
    input wire logic [BANK_W-1:0] access_bank,
    input wire logic [COL_W-1:0] access_col,
    input wire logic [MODE_W-1:0] mode_opcode,
    input wire logic mode_pulse
);
    // Command code as select, row, column, write.
    wire [3:0] c = {dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n};
    wire [BANK_W-1:0] b = {bank_select_hi, bank_select_lo};
    wire ap = addr_inputs[AP_BIT];
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    a_open_row_sets: assert property (
        c == 4'h3 |-> ##3 bank_active[$past(b, 3)])
        else $error("open row left the bank idle");
    a_row_addr_kept: assert property (
        c == 4'h3 |-> ##3 bank_rows[ADDR_W*$past(b, 3) +: ADDR_W]
        == $past(addr_inputs, 3)) else $error("row address wrong");
    a_pre_all_close: assert property (
        c == 4'h2 && ap |-> ##3 bank_active == 4'h0)
        else $error("precharge all left a bank open");
    a_pre_one_close: assert property (
        c == 4'h2 && !ap |-> ##3 !bank_active[$past(b, 3)])
        else $error("precharge left the bank open");
    a_read_fields: assert property (
        c == 4'h5 |-> ##3 access_pulse && !access_write
        && access_col == $past(addr_inputs[COL_W-1:0], 3)
        && access_bank == $past(b, 3) && access_auto_pre == $past(ap, 3))
        else $error("read access fields wrong");
    a_write_kind: assert property (
        c == 4'h4 |-> ##3 access_pulse && access_write)
        else $error("write not reported");
    a_mode_opcode: assert property (
        c == 4'h0 |-> ##3 mode_pulse && mode_opcode == $past(addr_inputs, 3))
        else $error("mode opcode wrong");
    a_select_masks: assert property (
        dev_select_n |-> ##3 !access_pulse && !mode_pulse
        && $stable(bank_active)) else $error("deselected command acted");
    // Main scenarios reached.
    cover property (c == 4'h3);
    cover property (access_pulse && access_auto_pre);
    cover property (mode_pulse);
endmodule : bank_cmd_chk

bind sdram_bank_row_command_decode bank_cmd_chk i_bank_cmd_chk (.*);

// >>> tb/mc_model.sv
`timescale 1ns/1ps
// Memory controller side: drives one command per call at the falling edge.
module mc_model
    import cmd_decode_pkg::*;
(
    // Clock in, command pins out.
    input wire logic clock,
    output logic dev_select_n,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic write_strobe_n,
    output logic bank_select_lo,
    output logic bank_select_hi,
    output logic [ADDR_W-1:0] addr_inputs
);
    // Start deselected so reset sees no command.
    initial
    begin
        {dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = 4'hf;
        {bank_select_hi, bank_select_lo, addr_inputs} = 15'h0000;
    end
    // Puts a command on the pins; it stays until the next call.
    task issue(input logic [3:0] c, input logic [1:0] b,
               input logic [ADDR_W-1:0] a);
        @(negedge clock);
        {dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n} = c;
        {bank_select_hi, bank_select_lo, addr_inputs} = {b, a};
    endtask : issue
    // Deselect; other lines flip so a stale value can never pass.
    task idle();
        @(negedge clock);
        dev_select_n = 1'b1;
        {row_strobe_n, col_strobe_n, write_strobe_n} =
            ~{row_strobe_n, col_strobe_n, write_strobe_n};
        {bank_select_hi, bank_select_lo, addr_inputs} =
            ~{bank_select_hi, bank_select_lo, addr_inputs};
    endtask : idle
endmodule : mc_model

// >>> tb/sdram_bank_row_command_decode_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected at %0t: %h vs %h", $time, (a), (e)); end end
module sdram_bank_row_command_decode_bench
    import cmd_decode_pkg::*;
;
    int error_cnt = 0;
    int compares = 0;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    wire dev_select_n, row_strobe_n, col_strobe_n, write_strobe_n;
    wire bank_select_lo, bank_select_hi;
    wire [ADDR_W-1:0] addr_inputs;
    logic [NUM_BANKS-1:0] bank_active;
    logic [NUM_BANKS*ADDR_W-1:0] bank_rows;
    logic access_pulse, access_write, access_auto_pre;
    logic [BANK_W-1:0] access_bank;
    logic [COL_W-1:0] access_col;
    logic [MODE_W-1:0] mode_opcode;
    logic mode_pulse, refresh_pulse, burst_stop_pulse;
    // A 40 MHz clock.
    always #12.5 clock = ~clock;
    mc_model i_mc_model (.*);
    sdram_bank_row_command_decode i_sdram_bank_row_command_decode (.*);
    // One command, then idle; look just after the third rising edge
    // counted from the sampling edge, while a pulse still stands.
    task run(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
        i_mc_model.issue(c, b, a);
        i_mc_model.idle();
        repeat (2) @(posedge clock);
        #1;
    endtask : run
    // Every bank pattern opens its own bank with its own row.
    task t_open_all();
        for (int i = 0; i < 4; i++)
            run(4'h3, 2'(i), 13'h1aa0 + 13'(i));
        `CHK(bank_active, 4'hf)
        for (int i = 0; i < 4; i++)
            `CHK(bank_rows[13*i +: 13], 13'h1aa0 + 13'(i))
        $display("test open_all done");
    endtask : t_open_all
    // Single bank close, a masked command, then a mode load.
    task t_close_mode();
        run(4'h2, 2'h1, 13'h1aff);
        `CHK(bank_active, 4'hd)
        `CHK(bank_rows[12:0], 13'h1aa0)
        run(4'h8, 2'h0, 13'h0400);
        `CHK(bank_active, 4'hd)
        `CHK(mode_opcode, 13'h0000)
        run(4'h0, 2'h3, 13'h1e5a);
        `CHK({mode_pulse, mode_opcode}, {1'b1, 13'h1e5a})
        $display("test close_mode done");
    endtask : t_close_mode
    // Read with auto precharge, a plain write right behind it, then close all.
    task t_access();
        i_mc_model.issue(4'h5, 2'h2, 13'h05a5);
        i_mc_model.issue(4'h4, 2'h0, 13'h1133);
        i_mc_model.idle();
        repeat (1) @(posedge clock);
        #1;
        `CHK({access_pulse, access_write}, 2'h2)
        `CHK({access_auto_pre, access_bank, access_col}, 12'hda5)
        `CHK(bank_active, 4'h9)
        @(posedge clock);
        #1;
        `CHK({access_pulse, access_write}, 2'h3)
        `CHK({access_auto_pre, access_bank, access_col}, 12'h133)
        @(posedge clock);
        #1;
        `CHK(access_pulse, 1'b0)
        run(4'h2, 2'h2, 13'h0400);
        `CHK(bank_active, 4'h0)
        $display("test access done");
    endtask : t_access
    // Refresh and burst stop each give one pulse, then both drop.
    task t_events();
        run(4'h1, 2'h0, 13'h0000);
        `CHK({refresh_pulse, burst_stop_pulse}, 2'h2)
        run(4'h6, 2'h0, 13'h0000);
        `CHK({refresh_pulse, burst_stop_pulse}, 2'h1)
        @(posedge clock);
        #1;
        `CHK({refresh_pulse, burst_stop_pulse}, 2'h0)
        $display("test events done");
    endtask : t_events
    // Prints the counts and the verdict, then stops.
    task complete_run();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        repeat (20) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        `CHK(bank_active, 4'h0)
        t_open_all();
        t_close_mode();
        t_access();
        t_events();
        complete_run();
    end
endmodule : sdram_bank_row_command_decode_bench
